//--- hw/ivm_top.sv
// Interrupt vector map: request merge, level registers, arbitration, vectors, status.
//
// Function
// - Pulse ch1 upper uses 0xFFE6/0xFFE7, third register.
// - Pulse ch2 upper uses 0xFFE4/0xFFE5, third register.
// - Pulse ch0 upper uses 0xFFE2/0xFFE3, fourth register.
// - Pulse ch0 lower uses 0xFFE0/0xFFE1, fourth register.
// - Pulse ch2 lower uses 0xFFDC/0xFFDD, fourth register.
// - Timer1 upper 0xFFDE fourth; lower 0xFFCE sixth.
// - Reload timer and motor write share 0xFFDA.
// - Bus, pulse timer, motor position share 0xFFD8.
// - Equal levels: lowest request number wins.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ivm_top
	import ivm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Register bus write address and data
	input wire logic [ADDR_W-1:0] s_axil_awaddr_i,
	input wire logic s_axil_awvalid_i,
	output logic s_axil_awready_o,
	input wire logic [31:0] s_axil_wdata_i,
	input wire logic [3:0] s_axil_wstrb_i,
	input wire logic s_axil_wvalid_i,
	output logic s_axil_wready_o,
	// Register bus write response
	output logic [1:0] s_axil_bresp_o,
	output logic s_axil_bvalid_o,
	input wire logic s_axil_bready_i,
	// Register bus read
	input wire logic [ADDR_W-1:0] s_axil_araddr_i,
	input wire logic s_axil_arvalid_i,
	output logic s_axil_arready_o,
	output logic [31:0] s_axil_rdata_o,
	output logic [1:0] s_axil_rresp_o,
	output logic s_axil_rvalid_o,
	input wire logic s_axil_rready_i,
	// Peripheral request lines, one per request number
	input wire logic [NUM_REQ-1:0] periph_req_i,
	// Sources that share a request number
	input wire logic reload_tmr_req_i,
	input wire logic motor_pulse_generator_wr_req_i,
	input wire logic two_wire_bus_req_i,
	input wire logic pulse_timer16_req_i,
	input wire logic motor_pulse_generator_pos_req_i,
	// CPU acceptance side
	input wire logic [1:0] cpu_cur_level_i,
	output logic cpu_int_req_o,
	output logic [4:0] cpu_int_num_o,
	output logic [1:0] cpu_int_level_o,
	output logic [15:0] cpu_vec_upper_o,
	output logic [15:0] cpu_vec_lower_o,
	// Status event interrupt
	output logic irq_o
);

	// Merged request lines, one per request number
	logic [NUM_REQ-1:0] req_comb;
	// Previous merged lines for edge detection
	logic [NUM_REQ-1:0] req_prev_q;
	// Level registers and their flat field view
	logic [7:0] lvl_q [NUM_LVL_REGS];
	logic [2*NUM_REQ-1:0] lvl_flat;
	// Sticky status and mask
	logic [NUM_REQ-1:0] stat_w;
	logic [NUM_REQ-1:0] mask_q;
	logic [NUM_REQ-1:0] stat_clr;
	// Bus write holding state
	logic aw_have_q;
	logic w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire;
	// Write decode results
	logic wr_lvl_hit;
	logic wr_stat_hit;
	logic wr_mask_hit;
	logic wr_ro_hit;
	logic [2:0] wr_lvl_idx;
	// Read decode results
	logic [31:0] rd_data;
	logic rd_hit;
	logic [2:0] rd_lvl_idx;
	// Arbiter result
	logic pick_found;
	logic [4:0] pick_num;
	logic [1:0] pick_lvl;
	logic grant;

	// Flat view: field n sits at bits 2n+1:2n, register n/4, bits (n%4)*2
	for (genvar g = 0; g < NUM_LVL_REGS; g++) begin : g_flat
		assign lvl_flat[g*8 +: 8] = lvl_q[g];
	end

	// Merge request lines; shared numbers stay high while any source is
	always_comb begin
		req_comb = periph_req_i;
		req_comb[REQ_SHARED_TMR] = periph_req_i[REQ_SHARED_TMR] | reload_tmr_req_i
			| motor_pulse_generator_wr_req_i;
		req_comb[REQ_SHARED_BUS] = periph_req_i[REQ_SHARED_BUS] | two_wire_bus_req_i
			| pulse_timer16_req_i | motor_pulse_generator_pos_req_i;
	end

	// Write address channel: hold one address until the write completes
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			aw_have_q <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axil_awvalid_i && s_axil_awready_o) begin
			aw_have_q <= 1'b1;
			awaddr_q <= s_axil_awaddr_i;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	// Write data channel: may arrive before or after the address
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			w_have_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axil_wvalid_i && s_axil_wready_o) begin
			w_have_q <= 1'b1;
			wdata_q <= s_axil_wdata_i;
			wstrb_q <= s_axil_wstrb_i;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	// Ready flops drop after a take so only one write is in flight
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			s_axil_awready_o <= 1'b1;
			s_axil_wready_o <= 1'b1;
		end else begin
			if (s_axil_awvalid_i && s_axil_awready_o) begin
				s_axil_awready_o <= 1'b0;
			end else if (s_axil_bvalid_o && s_axil_bready_i) begin
				s_axil_awready_o <= 1'b1;
			end
			if (s_axil_wvalid_i && s_axil_wready_o) begin
				s_axil_wready_o <= 1'b0;
			end else if (s_axil_bvalid_o && s_axil_bready_i) begin
				s_axil_wready_o <= 1'b1;
			end
		end
	end

	// The write lands once both halves are held and no response is pending
	assign wr_fire = aw_have_q && w_have_q && !s_axil_bvalid_o;

	// Write address decode; misaligned addresses count as unmapped
	always_comb begin
		wr_lvl_hit = 1'b0;
		wr_stat_hit = 1'b0;
		wr_mask_hit = 1'b0;
		wr_ro_hit = 1'b0;
		wr_lvl_idx = awaddr_q[4:2];
		if (awaddr_q[1:0] != 2'b00) begin
			wr_ro_hit = 1'b0;
		end else if (awaddr_q < LVL_REG_END_OFF) begin
			wr_lvl_hit = 1'b1;
		end else if (awaddr_q == STAT_OFF) begin
			wr_stat_hit = 1'b1;
		end else if (awaddr_q == MASK_OFF) begin
			wr_mask_hit = 1'b1;
		end else if (awaddr_q == PEND_OFF || awaddr_q == GRANT_OFF) begin
			// Read-only words accept writes and ignore them
			wr_ro_hit = 1'b1;
		end
	end

	// Write response: decode error for unmapped words
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			s_axil_bvalid_o <= 1'b0;
			s_axil_bresp_o <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axil_bvalid_o <= 1'b1;
			if (wr_lvl_hit || wr_stat_hit || wr_mask_hit || wr_ro_hit) begin
				s_axil_bresp_o <= RESP_OKAY;
			end else begin
				s_axil_bresp_o <= RESP_DECERR;
			end
		end else if (s_axil_bready_i) begin
			s_axil_bvalid_o <= 1'b0;
		end
	end

	// Level registers: only the low byte lane holds the four fields
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < NUM_LVL_REGS; i++) begin
				lvl_q[i] <= LVL_REG_RST;
			end
		end else if (wr_fire && wr_lvl_hit && wstrb_q[0]) begin
			lvl_q[wr_lvl_idx] <= wdata_q[7:0];
		end
	end

	// Mask register, byte lanes honoured; reset masks everything off
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			mask_q <= MASK_RST;
		end else if (wr_fire && wr_mask_hit) begin
			for (int b = 0; b < 3; b++) begin
				if (wstrb_q[b]) begin
					mask_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
				end
			end
		end
	end

	// Status clear mask: write one to clear, per enabled byte lane
	always_comb begin
		stat_clr = '0;
		if (wr_fire && wr_stat_hit) begin
			for (int b = 0; b < 3; b++) begin
				if (wstrb_q[b]) begin
					stat_clr[b*8 +: 8] = wdata_q[b*8 +: 8];
				end
			end
		end
	end

	// Rising edges of merged lines are the status events
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			req_prev_q <= '0;
		end else begin
			req_prev_q <= req_comb;
		end
	end

	// Sticky event bits; a new edge beats a simultaneous clear
	ivm_sticky_bits #(
		.WIDTH(NUM_REQ)
	) u_status (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.set_i(req_comb & ~req_prev_q),
		.clr_i(stat_clr),
		.status_o(stat_w)
	);

	// Level interrupt while any unmasked status bit is set
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat_w & mask_q);
		end
	end

	ivm_prio_pick #(
		.N(NUM_REQ)
	) u_pick (
		.req_i(req_comb),
		.lvl_i(lvl_flat),
		.found_o(pick_found),
		.num_o(pick_num),
		.lvl_o(pick_lvl)
	);

	// Only a request stronger than the CPU's current level is offered
	assign grant = pick_found && (pick_lvl < cpu_cur_level_i);

	// CPU-facing outputs; vector address follows the number every cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cpu_int_req_o <= 1'b0;
			cpu_int_num_o <= '0;
			cpu_int_level_o <= 2'h3;
			cpu_vec_upper_o <= VEC_TOP;
			cpu_vec_lower_o <= VEC_TOP + 16'h0001;
		end else begin
			cpu_int_req_o <= grant;
			cpu_int_num_o <= pick_num;
			cpu_int_level_o <= pick_lvl;
			cpu_vec_upper_o <= vec_upper(pick_num);
			cpu_vec_lower_o <= vec_upper(pick_num) + 16'h0001;
		end
	end

	// Read decode, if and else-if by address
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		rd_lvl_idx = s_axil_araddr_i[4:2];
		if (s_axil_araddr_i[1:0] != 2'b00) begin
			rd_hit = 1'b0;
		end else if (s_axil_araddr_i < LVL_REG_END_OFF) begin
			rd_data[7:0] = lvl_q[rd_lvl_idx];
		end else if (s_axil_araddr_i == STAT_OFF) begin
			rd_data[NUM_REQ-1:0] = stat_w;
		end else if (s_axil_araddr_i == MASK_OFF) begin
			rd_data[NUM_REQ-1:0] = mask_q;
		end else if (s_axil_araddr_i == PEND_OFF) begin
			rd_data[NUM_REQ-1:0] = req_comb;
		end else if (s_axil_araddr_i == GRANT_OFF) begin
			rd_data[GRANT_NUM_LSB +: 5] = cpu_int_num_o;
			rd_data[GRANT_LVL_LSB +: 2] = cpu_int_level_o;
			rd_data[GRANT_VALID_BIT] = cpu_int_req_o;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Read channel: one read in flight, data one cycle after the take
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			s_axil_arready_o <= 1'b1;
			s_axil_rvalid_o <= 1'b0;
			s_axil_rdata_o <= '0;
			s_axil_rresp_o <= RESP_OKAY;
		end else if (s_axil_arvalid_i && s_axil_arready_o) begin
			s_axil_arready_o <= 1'b0;
			s_axil_rvalid_o <= 1'b1;
			s_axil_rdata_o <= rd_data;
			s_axil_rresp_o <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axil_rvalid_o && s_axil_rready_i) begin
			s_axil_arready_o <= 1'b1;
			s_axil_rvalid_o <= 1'b0;
		end
	end

	// Vector checks: the number on offer carries its documented address
	property p_vec_pg1_up;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(cpu_int_num_o == REQ_PG1_UPPER) |-> (cpu_vec_upper_o == VEC_PG1_UPPER)
			&& (cpu_vec_lower_o == VEC_PG1_UPPER + 16'h0001);
	endproperty
	a_vec_pg1_up: assert property (p_vec_pg1_up) else $error("bad ch1 upper vector");

	property p_vec_pg2_up;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(cpu_int_num_o == REQ_PG2_UPPER) |-> (cpu_vec_upper_o == VEC_PG2_UPPER);
	endproperty
	a_vec_pg2_up: assert property (p_vec_pg2_up) else $error("bad ch2 upper vector");

	property p_vec_pg0_up;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(cpu_int_num_o == REQ_PG0_UPPER) |-> (cpu_vec_upper_o == VEC_PG0_UPPER);
	endproperty
	a_vec_pg0_up: assert property (p_vec_pg0_up) else $error("bad ch0 upper vector");

	property p_vec_pg0_lo;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(cpu_int_num_o == REQ_PG0_LOWER) |-> (cpu_vec_upper_o == VEC_PG0_LOWER);
	endproperty
	a_vec_pg0_lo: assert property (p_vec_pg0_lo) else $error("bad ch0 lower vector");

	property p_vec_pg2_lo;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(cpu_int_num_o == REQ_PG2_LOWER) |-> (cpu_vec_upper_o == VEC_PG2_LOWER);
	endproperty
	a_vec_pg2_lo: assert property (p_vec_pg2_lo) else $error("bad ch2 lower vector");

	property p_vec_ct1;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		((cpu_int_num_o == REQ_CT1_UPPER) |-> (cpu_vec_upper_o == VEC_CT1_UPPER))
		and ((cpu_int_num_o == REQ_CT1_LOWER) |-> (cpu_vec_upper_o == VEC_CT1_LOWER));
	endproperty
	a_vec_ct1: assert property (p_vec_ct1) else $error("bad timer1 vector");

	// A lone reload timer event at strongest level reaches the CPU next cycle;
	// every lower number must be quiet, since one at level 0 would win instead
	sequence s_tmr_alone;
		reload_tmr_req_i && (lvl_q[4][1:0] == 2'h0) && (cpu_cur_level_i == 2'h3)
			&& (periph_req_i[15:0] == '0);
	endsequence
	property p_shared_tmr;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_tmr_alone |=> cpu_int_req_o && (cpu_int_num_o == REQ_SHARED_TMR)
			&& (cpu_vec_upper_o == VEC_SHARED_TMR);
	endproperty
	a_shared_tmr: assert property (p_shared_tmr) else $error("timer share lost");

	// Any one bus-shared source alone at strongest level is offered on its vector
	sequence s_bus_alone;
		(two_wire_bus_req_i || pulse_timer16_req_i || motor_pulse_generator_pos_req_i)
			&& (lvl_q[4][3:2] == 2'h0) && (cpu_cur_level_i == 2'h3)
			&& (periph_req_i[16:0] == '0) && !reload_tmr_req_i
			&& !motor_pulse_generator_wr_req_i;
	endsequence
	property p_shared_bus;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_bus_alone |=> cpu_int_req_o && (cpu_int_num_o == REQ_SHARED_BUS)
			&& (cpu_vec_upper_o == VEC_SHARED_BUS);
	endproperty
	a_shared_bus: assert property (p_shared_bus) else $error("bus share lost");

	// Request 0 pending at the granted level must have won
	property p_prio_low_num;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		($past(req_comb[0]) && cpu_int_req_o && ($past(lvl_q[0][1:0]) == cpu_int_level_o))
			|-> (cpu_int_num_o == 5'h00);
	endproperty
	a_prio_low_num: assert property (p_prio_low_num) else $error("priority order");

	// Dropping every timer-shared source drops the timer's shared line
	property p_shared_release;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(!periph_req_i[REQ_SHARED_TMR] && !reload_tmr_req_i
			&& !motor_pulse_generator_wr_req_i) |-> !req_comb[REQ_SHARED_TMR];
	endproperty
	a_shared_release: assert property (p_shared_release) else $error("share stuck");

endmodule
`default_nettype wire

//--- hw/ivm_pkg.sv
// Constants shared by the interrupt vector map: offsets, fields, vectors, reset values.
package ivm_pkg;

	// Number of request numbers and level registers
	localparam int NUM_REQ = 24;
	localparam int NUM_LVL_REGS = 6;
	localparam int REQ_NUM_W = 5;
	localparam int LVL_W = 2;
	localparam int ADDR_W = 8;

	// Register byte offsets on the register bus
	localparam logic [7:0] LVL_REG_BASE_OFF = 8'h00;
	localparam logic [7:0] LVL_REG_END_OFF = 8'h18;
	localparam logic [7:0] STAT_OFF = 8'h18;
	localparam logic [7:0] MASK_OFF = 8'h1c;
	localparam logic [7:0] PEND_OFF = 8'h20;
	localparam logic [7:0] GRANT_OFF = 8'h24;

	// Reset values: every level field starts at the weakest level
	localparam logic [7:0] LVL_REG_RST = 8'hff;
	localparam logic [23:0] MASK_RST = 24'h000000;

	// Grant register field positions
	localparam int GRANT_NUM_LSB = 0;
	localparam int GRANT_LVL_LSB = 8;
	localparam int GRANT_VALID_BIT = 16;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	// Upper byte address of request 0; each later request sits two bytes lower
	localparam logic [15:0] VEC_TOP = 16'hfffa;

	// Request numbers named by the sources that use them
	localparam logic [4:0] REQ_PG1_UPPER = 5'h0a;
	localparam logic [4:0] REQ_PG2_UPPER = 5'h0b;
	localparam logic [4:0] REQ_PG0_UPPER = 5'h0c;
	localparam logic [4:0] REQ_PG0_LOWER = 5'h0d;
	localparam logic [4:0] REQ_CT1_UPPER = 5'h0e;
	localparam logic [4:0] REQ_PG2_LOWER = 5'h0f;
	localparam logic [4:0] REQ_SHARED_TMR = 5'h10;
	localparam logic [4:0] REQ_SHARED_BUS = 5'h11;
	localparam logic [4:0] REQ_CT1_LOWER = 5'h16;

	// Vector upper-byte addresses expected for those requests
	localparam logic [15:0] VEC_PG1_UPPER = 16'hffe6;
	localparam logic [15:0] VEC_PG2_UPPER = 16'hffe4;
	localparam logic [15:0] VEC_PG0_UPPER = 16'hffe2;
	localparam logic [15:0] VEC_PG0_LOWER = 16'hffe0;
	localparam logic [15:0] VEC_CT1_UPPER = 16'hffde;
	localparam logic [15:0] VEC_PG2_LOWER = 16'hffdc;
	localparam logic [15:0] VEC_SHARED_TMR = 16'hffda;
	localparam logic [15:0] VEC_SHARED_BUS = 16'hffd8;
	localparam logic [15:0] VEC_CT1_LOWER = 16'hffce;

	// Upper-byte vector address of a request number
	function automatic logic [15:0] vec_upper(input logic [4:0] num);
		vec_upper = VEC_TOP - {10'h000, num, 1'b0};
	endfunction

endpackage

//--- hw/ivm_sticky_bits.sv
// Sticky event bits with write-one-to-clear, where a new event beats a clear.
`timescale 1ns/1ps
`default_nettype none
module ivm_sticky_bits #(
	parameter int WIDTH = 24
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Events and clears
	input wire logic [WIDTH-1:0] set_i,
	input wire logic [WIDTH-1:0] clr_i,
	// Held status
	output logic [WIDTH-1:0] status_o
);

	// One flop per event; set has priority so no event is lost
	for (genvar g = 0; g < WIDTH; g++) begin : g_bit
		always_ff @(posedge sys_clk_i) begin
			if (!rst_b_i) begin
				status_o[g] <= 1'b0;
			end else if (set_i[g]) begin
				status_o[g] <= 1'b1;
			end else if (clr_i[g]) begin
				status_o[g] <= 1'b0;
			end
		end
	end

	// A bit that sees a set is high next cycle even under a clear
	property p_set_wins;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(set_i != '0) |=> ((status_o & $past(set_i)) == $past(set_i));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("sticky set lost");

endmodule
`default_nettype wire

//--- hw/ivm_prio_pick.sv
// Picks the strongest pending request: lowest level value, then lowest number.
`timescale 1ns/1ps
`default_nettype none
module ivm_prio_pick #(
	parameter int N = 24
) (
	// Pending lines and their two-bit levels, field n at bits 2n+1:2n
	input wire logic [N-1:0] req_i,
	input wire logic [2*N-1:0] lvl_i,
	// Result
	output logic found_o,
	output logic [4:0] num_o,
	output logic [1:0] lvl_o
);

	// Scan from the weakest number down so ties settle on the lowest number
	always_comb begin
		found_o = 1'b0;
		num_o = 5'h00;
		lvl_o = 2'h3;
		for (int i = N - 1; i >= 0; i--) begin
			if (req_i[i] && (!found_o || lvl_i[2*i +: 2] <= lvl_o)) begin
				found_o = 1'b1;
				num_o = 5'(i);
				lvl_o = lvl_i[2*i +: 2];
			end
		end
	end

endmodule
`default_nettype wire

//--- dv/ivm_cpu_model.sv
// CPU-side partner model: current level register and vector fetch.
`timescale 1ns/1ps
`default_nettype none
module ivm_cpu_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Offered request from the map
	input wire logic int_req_i,
	input wire logic [4:0] int_num_i,
	input wire logic [15:0] vec_upper_i,
	input wire logic [15:0] vec_lower_i,
	// Bench control: level in effect and acceptance delay
	input wire logic [1:0] run_level_i,
	input wire logic [1:0] wait_i,
	// Level to the map and what was fetched
	output logic [1:0] cur_level_o,
	output logic fetched_o,
	output logic [4:0] fetch_num_o,
	output logic [31:0] fetch_vec_o
);
	// Cycles the request has been waiting
	logic [1:0] cnt_q;

	// Level in effect; starts weakest so only levels 0..2 get through
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cur_level_o <= 2'h3;
		end else begin
			cur_level_o <= run_level_i;
		end
	end

	// Fetch after a chosen delay; a dropped request cancels the fetch
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i || !int_req_i) begin
			cnt_q <= 2'h0;
			fetched_o <= 1'b0;
		end else if (cnt_q == wait_i) begin
			fetched_o <= 1'b1;
			fetch_num_o <= int_num_i;
			fetch_vec_o <= {vec_upper_i, vec_lower_i};
		end else begin
			cnt_q <= cnt_q + 2'h1;
		end
	end
endmodule
`default_nettype wire

//--- dv/ivm_tb.sv
// Self-checking bench for the interrupt vector map.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ivm_pkg::*;
	// Clock, reset and bus signals
	logic clk, rst_b;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	// Requests: bits 23:0 numbered lines, 28:24 shared sources
	logic [28:0] req_all;
	logic [1:0] run_level, wait_n;
	wire logic [1:0] cur_level, int_level;
	wire logic int_req, irq, fetched;
	wire logic [4:0] int_num, fetch_num;
	wire logic [15:0] vec_up, vec_lo;
	wire logic [31:0] fetch_vec;
	int bad_count, checked, cycles;

	ivm_top i_ivm_top (.sys_clk_i(clk), .rst_b_i(rst_b),
		.s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready),
		.s_axil_wdata_i(wdata), .s_axil_wstrb_i(wstrb), .s_axil_wvalid_i(wvalid),
		.s_axil_wready_o(wready), .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bvalid),
		.s_axil_bready_i(bready), .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
		.s_axil_arready_o(arready), .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp),
		.s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready), .periph_req_i(req_all[23:0]),
		.reload_tmr_req_i(req_all[24]), .motor_pulse_generator_wr_req_i(req_all[25]),
		.two_wire_bus_req_i(req_all[26]), .pulse_timer16_req_i(req_all[27]),
		.motor_pulse_generator_pos_req_i(req_all[28]), .cpu_cur_level_i(cur_level),
		.cpu_int_req_o(int_req), .cpu_int_num_o(int_num), .cpu_int_level_o(int_level),
		.cpu_vec_upper_o(vec_up), .cpu_vec_lower_o(vec_lo), .irq_o(irq));

	ivm_cpu_model i_ivm_cpu_model (.sys_clk_i(clk), .rst_b_i(rst_b), .int_req_i(int_req),
		.int_num_i(int_num), .vec_upper_i(vec_up), .vec_lower_i(vec_lo),
		.run_level_i(run_level), .wait_i(wait_n), .cur_level_o(cur_level),
		.fetched_o(fetched), .fetch_num_o(fetch_num), .fetch_vec_o(fetch_vec));

	// Clock at 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Hang guard: far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("compares %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Write one word; address and data released as each is taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_done, w_done;
		@(posedge clk);
		awaddr <= a; wdata <= d; wstrb <= 4'hf;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		aw_done = 0; w_done = 0;
		forever begin
			@(posedge clk);
			if (!aw_done && awready) begin aw_done = 1; awvalid <= 1'b0; end
			if (!w_done && wready) begin w_done = 1; wvalid <= 1'b0; end
			if (bvalid) begin r = bresp; bready <= 1'b0; break; end
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit a_done;
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		a_done = 0;
		forever begin
			@(posedge clk);
			if (!a_done && arready) begin a_done = 1; arvalid <= 1'b0; end
			if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
		end
	endtask

	// Level field n to v, others of that register weakest
	task automatic set_lvl(input logic [4:0] n, input logic [1:0] v);
		logic [1:0] r;
		axi_wr({3'h0, n[4:2], 2'h0}, 32'hff & ~(32'h3 << (2 * n[1:0]))
			| (32'(v) << (2 * n[1:0])), r);
	endtask

	task automatic drive(input logic [28:0] v);
		@(posedge clk);
		req_all <= v;
	endtask

	// Offer one source at strongest level and check the fetched vector
	task automatic vec_case(input logic [4:0] n, input int src, input logic [15:0] v);
		set_lvl(n, 2'h0);
		drive(29'h1 << src);
		cyc(4);
		chk(32'(fetched), 32'h1);
		chk(32'(fetch_num), 32'(n));
		chk(fetch_vec, {v, v + 16'h1});
		chk(32'(int_level), 32'h0);
		drive(29'h0);
		set_lvl(n, 2'h3);
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(8'h08, d, r);
		chk({24'h0, d[7:0]}, 32'hff);
		axi_rd(MASK_OFF, d, r);
		chk(d, 32'h0);
		chk(32'(int_req), 32'h0);
		$display("test reset done");
	endtask

	task automatic t_vectors();
		vec_case(REQ_PG1_UPPER, 10, 16'hffe6);
		vec_case(REQ_PG2_UPPER, 11, 16'hffe4);
		vec_case(REQ_PG0_UPPER, 12, 16'hffe2);
		vec_case(REQ_PG0_LOWER, 13, 16'hffe0);
		vec_case(REQ_PG2_LOWER, 15, 16'hffdc);
		vec_case(REQ_CT1_UPPER, 14, 16'hffde);
		vec_case(REQ_CT1_LOWER, 22, 16'hffce);
		$display("test vectors done");
	endtask

	task automatic t_shared();
		vec_case(REQ_SHARED_TMR, 24, 16'hffda);
		vec_case(REQ_SHARED_TMR, 25, 16'hffda);
		vec_case(REQ_SHARED_BUS, 26, 16'hffd8);
		vec_case(REQ_SHARED_BUS, 27, 16'hffd8);
		vec_case(REQ_SHARED_BUS, 28, 16'hffd8);
		// One source dropping must not hide the other
		set_lvl(REQ_SHARED_BUS, 2'h0);
		drive(29'h14000000);
		drive(29'h10000000);
		cyc(3);
		chk({23'h0, int_req, 3'h0, int_num}, {23'h0, 1'b1, 3'h0, REQ_SHARED_BUS});
		drive(29'h0);
		set_lvl(REQ_SHARED_BUS, 2'h3);
		$display("test shared done");
	endtask

	task automatic t_priority();
		logic [1:0] r;
		wait_n <= 2'h2;
		// Fields 10 and 11 both at level 1: the lower number wins the tie
		axi_wr(8'h08, 32'h5f, r);
		drive(29'h0c00);
		cyc(6);
		chk({23'h0, fetched, 3'h0, fetch_num}, {23'h0, 1'b1, 3'h0, REQ_PG1_UPPER});
		// Field 11 stronger than field 10: level beats number
		axi_wr(8'h08, 32'h1f, r);
		cyc(6);
		chk(32'(int_num), 32'(REQ_PG2_UPPER));
		axi_wr(8'h08, 32'h5f, r);
		run_level <= 2'h1;
		cyc(4);
		chk(32'(int_req), 32'h0);
		// Request 0 ties with 10 and 11 at level 1 and must win
		run_level <= 2'h3;
		axi_wr(8'h00, 32'hfd, r);
		drive(29'h0c01);
		cyc(3);
		chk({23'h0, int_req, 3'h0, int_num}, 32'h100);
		wait_n <= 2'h0;
		drive(29'h0);
		axi_wr(8'h08, 32'hff, r);
		axi_wr(8'h00, 32'hff, r);
		$display("test priority done");
	endtask

	task automatic t_irq();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(STAT_OFF, 32'h00ffffff, r);
		drive(29'h1000);
		drive(29'h0);
		axi_rd(STAT_OFF, d, r);
		chk(d, 32'h1000);
		chk(32'(irq), 32'h0);
		axi_wr(MASK_OFF, 32'h1000, r);
		cyc(3);
		chk(32'(irq), 32'h1);
		axi_wr(STAT_OFF, 32'h1000, r);
		cyc(3);
		chk(32'(irq), 32'h0);
		axi_rd(8'h40, d, r);
		chk({30'h0, r}, 32'(RESP_DECERR));
		axi_wr(8'h40, 32'h1, r);
		chk({30'h0, r}, 32'(RESP_DECERR));
		$display("test irq done");
	endtask

	initial begin
		rst_b = 1'b0; awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'h0;
		awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
		req_all = 29'h0; run_level = 2'h3; wait_n = 2'h0;
		bad_count = 0; checked = 0; cycles = 0;
		cyc(3);
		rst_b <= 1'b1;
		t_reset();
		t_vectors();
		t_shared();
		t_priority();
		t_irq();
		close_out();
	end
endmodule
`default_nettype wire
